// file: pin_select_pkg.sv
// Package with register map and constants for the port pin function select block
package pin_select_pkg;
  // Register byte offsets
  localparam logic [7:0] port5_ctrl_offset = 8'h00;   // P5 out, dir, select bits
  localparam logic [7:0] port6_ctrl_offset = 8'h04;   // P6 out, dir, select, disable
  localparam logic [7:0] comp_ctrl_offset = 8'h08;    // Comparator channel select
  localparam logic [7:0] portj_ctrl_offset = 8'h0C;   // PJ out, dir, pull enable
  localparam logic [7:0] pin_status_offset = 8'h10;   // Pin input levels
  localparam logic [7:0] pin_effect_offset = 8'h14;   // Resolved drive enables

  // Field positions in port5_ctrl
  localparam int p5_out_lsb = 0;        // 8 bits output data
  localparam int p5_dir_lsb = 8;        // 8 bits direction
  localparam int p5_sel4_bit = 16;      // Pin 4 function select
  localparam int p5_bypass_bit = 17;    // Oscillator bypass

  // Field positions in port6_ctrl
  localparam int p6_out_lsb = 0;
  localparam int p6_dir_lsb = 8;
  localparam int p6_sel_lsb = 16;
  localparam int p6_dis_lsb = 24;

  // Field positions in comp_ctrl
  localparam int comp_en_bit = 4;       // Comparator mux active
  localparam int comp_ch_lsb = 0;       // 4 bit channel number

  // Field positions in portj_ctrl
  localparam int pj_out_lsb = 0;
  localparam int pj_dir_lsb = 4;
  localparam int pj_ren_lsb = 8;

  // Reset value and JTAG pull-up mask
  localparam logic [31:0] ctrl_reset = 32'h0000_0000;
  localparam logic [3:0] jtag_pull_mask = 4'he;      // TDI, TMS, TCK pull-ups

  // Pins
  localparam int osc_in_pin = 4;
  localparam int osc_out_pin = 5;
endpackage

// file: port_pin_function_select.sv
// Pin function select logic for port 5 oscillator pins, port 6 analog pins and port J
//
// Functional notes
// R1 - Pin4 select disables GPIO; bypass picks mode
// R2 - Pin5 taken only in crystal mode
// R3 - Analog disable kills driver and Schmitt input
// R4 - Selected comparator channel kills driver, input
// R5 - JTAG mode forces pull-ups, ignores pull enable
// R6 - JTAG controls port J direction
// R7 - Otherwise GPIO; direction 0 in, 1 out
`timescale 1ns/1ps
module port_pin_function_select
  import pin_select_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [7:0] port5_in,
  output logic [7:0] port5_out,
  output logic [7:0] port5_oe,
  output logic [7:0] port5_ie,
  input wire logic [7:0] port6_in,
  output logic [7:0] port6_out,
  output logic [7:0] port6_oe,
  output logic [7:0] port6_ie,
  input wire logic [3:0] portj_in,
  output logic [3:0] portj_out,
  output logic [3:0] portj_oe,
  output logic [3:0] portj_pull,
  input wire logic jtag_mode,
  input wire logic [3:0] jtag_out,
  input wire logic [3:0] jtag_oe,
  output logic osc_enable,
  output logic osc_bypass_mode,
  output logic [7:0] port6_analog
);
  import pin_select_pkg::*;

  // Software control words
  logic [31:0] port5_ctrl;
  logic [31:0] port6_ctrl;
  logic [31:0] comp_ctrl;
  logic [31:0] portj_ctrl;
  // Combinational pin resolution, registered before it reaches the pins
  // Registering costs one cycle of latency but keeps the pins glitch free
  logic [7:0] next_p5_oe; // Port 5 driver enables
  logic [7:0] next_p5_ie; // Port 5 Schmitt input enables
  logic [7:0] next_p6_oe; // Port 6 driver enables
  logic [7:0] next_p6_ie; // Port 6 Schmitt input enables
  logic [7:0] next_p6_an; // Port 6 pins in analog use
  logic [3:0] next_pj_oe; // Port J driver enables
  logic [3:0] next_pj_out; // Port J output data
  logic [3:0] next_pj_pull; // Port J pull-up enables
  logic [7:0] comp_onehot; // Pin picked by the comparator mux
  logic [31:0] next_rdata; // Read data before the answer register
  // Bus decode
  logic wr_en; // Write to a mapped word in the access cycle
  logic access; // Access phase of a transfer
  logic setup; // Setup phase of a transfer
  logic bad_addr; // Offset outside the map

  // Decode a register offset as mapped
  function automatic logic is_mapped(input logic [7:0] a);
    return (a == port5_ctrl_offset) || (a == port6_ctrl_offset) || (a == comp_ctrl_offset)
        || (a == portj_ctrl_offset) || (a == pin_status_offset) || (a == pin_effect_offset);
  endfunction

  // Access phase, always answered in the first access cycle
  assign access = psel && penable;
  // Setup phase is where the answer registers are loaded
  assign setup = psel && !penable;
  assign bad_addr = !is_mapped(paddr);
  assign wr_en = access && pwrite && !bad_addr;

  // Register writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port5_ctrl <= ctrl_reset;
      port6_ctrl <= ctrl_reset;
      comp_ctrl <= ctrl_reset;
      portj_ctrl <= ctrl_reset;
    end else if (wr_en) begin
      unique case (paddr)
        port5_ctrl_offset: port5_ctrl <= {14'h0000, pwdata[17:0]};
        port6_ctrl_offset: port6_ctrl <= pwdata;
        comp_ctrl_offset: comp_ctrl <= {27'h000_0000, pwdata[4:0]};
        portj_ctrl_offset: portj_ctrl <= {20'h0_0000, pwdata[11:0]};
        default: ;  // Status words are read only
      endcase
    end
  end

  // One-hot of the comparator channel; only real port 6 channels count
  always_comb begin
    comp_onehot = 8'h00;
    if (comp_ctrl[comp_en_bit] && comp_ctrl[comp_ch_lsb+3] == 1'b0) begin
      comp_onehot[comp_ctrl[comp_ch_lsb +: 3]] = 1'b1;
    end
  end

  // Port 5 resolution
  always_comb begin
    // Plain GPIO by default
    next_p5_oe = port5_ctrl[p5_dir_lsb +: 8];  // R7
    next_p5_ie = 8'hff;
    if (port5_ctrl[p5_sel4_bit]) begin
      // Oscillator owns the input pin in either mode
      next_p5_oe[osc_in_pin] = 1'b0;  // R1
      next_p5_ie[osc_in_pin] = 1'b0;  // R1
      if (!port5_ctrl[p5_bypass_bit]) begin
        // Crystal needs the output pin too; bypass leaves it as GPIO
        next_p5_oe[osc_out_pin] = 1'b0;  // R2
        next_p5_ie[osc_out_pin] = 1'b0;  // R2
      end
    end
  end

  // Port 6 resolution; analog pins lose driver and Schmitt input
  always_comb begin
    next_p6_an = port6_ctrl[p6_sel_lsb +: 8] | port6_ctrl[p6_dis_lsb +: 8] | comp_onehot;  // R3 R4
    next_p6_oe = port6_ctrl[p6_dir_lsb +: 8] & ~next_p6_an;  // R3 R4 R7
    next_p6_ie = ~next_p6_an;  // R3 R4
  end

  // Port J resolution
  // Test mode takes the whole port; software bits are kept but have no effect
  always_comb begin
    // Software view by default
    next_pj_oe = portj_ctrl[pj_dir_lsb +: 4];  // R7
    next_pj_out = portj_ctrl[pj_out_lsb +: 4];
    next_pj_pull = portj_ctrl[pj_ren_lsb +: 4];
    if (jtag_mode) begin
      // Test logic steers direction and forces pull-ups
      next_pj_oe = jtag_oe;  // R6
      next_pj_out = jtag_out;
      next_pj_pull = jtag_pull_mask & ~jtag_oe;  // R5
    end
  end

  // Read mux
  // The pin status word shows what the pins really see after input gating
  // Unmapped offsets read as zero and raise an error in the answer
  always_comb begin
    next_rdata = 32'h0000_0000;
    unique case (paddr)
      port5_ctrl_offset: next_rdata = port5_ctrl;
      port6_ctrl_offset: next_rdata = port6_ctrl;
      comp_ctrl_offset: next_rdata = comp_ctrl;
      portj_ctrl_offset: next_rdata = portj_ctrl;
      pin_status_offset: next_rdata = {4'h0, portj_in, port6_in & port6_ie, 8'h00,
                                       port5_in & port5_ie};
      pin_effect_offset: next_rdata = {4'h0, portj_oe, port6_oe, 8'h00, port5_oe};
      default: next_rdata = 32'h0000_0000;
    endcase
  end

  // Bus answer registers; ready in the first access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      // Loaded in setup, so the answer stands through the first access cycle
      pready <= setup;
      pslverr <= setup && bad_addr;
      // Zero outside the answer cycle so stale data never leaks
      prdata <= (setup && !pwrite) ? next_rdata : 32'h0000_0000;
    end
  end

  // Registered pin controls; one cycle after the control write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port5_out <= 8'h00;
      port5_oe <= 8'h00;
      port5_ie <= 8'hff;
      port6_out <= 8'h00;
      port6_oe <= 8'h00;
      port6_ie <= 8'hff;
      port6_analog <= 8'h00;
      portj_out <= 4'h0;
      portj_oe <= 4'h0;
      portj_pull <= 4'h0;
      osc_enable <= 1'b0;
      osc_bypass_mode <= 1'b0;
    end else begin
      port5_out <= port5_ctrl[p5_out_lsb +: 8];
      port5_oe <= next_p5_oe;
      port5_ie <= next_p5_ie;
      port6_out <= port6_ctrl[p6_out_lsb +: 8];
      port6_oe <= next_p6_oe;
      port6_ie <= next_p6_ie;
      port6_analog <= next_p6_an;
      portj_out <= next_pj_out;
      portj_oe <= next_pj_oe;
      portj_pull <= next_pj_pull;
      osc_enable <= port5_ctrl[p5_sel4_bit];  // R1
      osc_bypass_mode <= port5_ctrl[p5_bypass_bit];  // R1
    end
  end

  // Checks; pin outputs lag the control words by one edge
  // Oscillator input pin leaves GPIO in both modes
  osc_pin_off_a: assert property (@(posedge pclk) disable iff (!presetn)  // R1
    port5_ctrl[p5_sel4_bit] |=> !port5_oe[osc_in_pin] && !port5_ie[osc_in_pin])
    else $error("oscillator input pin still driven");

  // Bypass flag reaches the oscillator unchanged
  osc_mode_a: assert property (@(posedge pclk) disable iff (!presetn)  // R1
    1'b1 |=> osc_bypass_mode == $past(port5_ctrl[p5_bypass_bit]))
    else $error("oscillator mode not followed");

  // Bypass mode hands the output pin back to GPIO
  osc_out_pin_a: assert property (@(posedge pclk) disable iff (!presetn)  // R2
    port5_ctrl[p5_sel4_bit] && port5_ctrl[p5_bypass_bit]
    |=> port5_oe[osc_out_pin] == $past(port5_ctrl[p5_dir_lsb+osc_out_pin]))
    else $error("bypass mode lost output pin gpio");

  // Crystal mode takes the output pin too
  crystal_out_a: assert property (@(posedge pclk) disable iff (!presetn)  // R2
    port5_ctrl[p5_sel4_bit] && !port5_ctrl[p5_bypass_bit] |=> !port5_ie[osc_out_pin])
    else $error("crystal mode output pin still gpio");

  // Analog-disabled pins never drive
  analog_off_a: assert property (@(posedge pclk) disable iff (!presetn)  // R3
    |port6_ctrl[p6_dis_lsb +: 8] |=> (port6_oe & $past(port6_ctrl[p6_dis_lsb +: 8])) == 8'h00)
    else $error("disabled analog pin driven");

  // Comparator channel loses its input buffer
  comp_chan_a: assert property (@(posedge pclk) disable iff (!presetn)  // R4
    |comp_onehot |=> (port6_ie & $past(comp_onehot)) == 8'h00)
    else $error("comparator channel input buffer on");

  // Test inputs get their pull-ups while test logic is not driving
  jtag_pull_a: assert property (@(posedge pclk) disable iff (!presetn)  // R5
    jtag_mode && jtag_oe == 4'h0 |=> portj_pull[3:1] == 3'b111)
    else $error("jtag pull-ups missing");

  // Test data out has no forced pull
  tdo_pull_a: assert property (@(posedge pclk) disable iff (!presetn)  // R5
    jtag_mode |=> !portj_pull[0])
    else $error("test output pin pulled");

  // Test logic steers port J direction
  jtag_dir_a: assert property (@(posedge pclk) disable iff (!presetn)  // R6
    jtag_mode |=> portj_oe == $past(jtag_oe))
    else $error("port j direction not from jtag");

  // Port J GPIO direction from software
  gpio_dir_a: assert property (@(posedge pclk) disable iff (!presetn)  // R7
    !jtag_mode |=> portj_oe == $past(portj_ctrl[pj_dir_lsb +: 4]))
    else $error("port j gpio direction wrong");

  // Port 5 GPIO direction from software while the oscillator is off
  p5_gpio_dir_a: assert property (@(posedge pclk) disable iff (!presetn)  // R7
    !port5_ctrl[p5_sel4_bit] |=> port5_oe == $past(port5_ctrl[p5_dir_lsb +: 8]))
    else $error("port 5 gpio direction wrong");

  // Port 6 never drives a pin set as input
  p6_gpio_dir_a: assert property (@(posedge pclk) disable iff (!presetn)  // R7
    1'b1 |=> (port6_oe & ~$past(port6_ctrl[p6_dir_lsb +: 8])) == 8'h00)
    else $error("port 6 input pin driven");

  // Answer comes in the first access cycle
  bus_ready_a: assert property (@(posedge pclk) disable iff (!presetn)
    psel && !penable |=> pready)
    else $error("apb answer late");

  // Ready is a single-cycle pulse
  ready_pulse_a: assert property (@(posedge pclk) disable iff (!presetn)
    pready |=> !pready)
    else $error("apb ready held too long");

  // Unmapped offsets answer with an error
  bad_addr_err_a: assert property (@(posedge pclk) disable iff (!presetn)
    psel && !penable && !is_mapped(paddr) |=> pslverr && pready)
    else $error("unmapped offset without error");

  // Read data is zero outside the answer cycle
  rdata_idle_a: assert property (@(posedge pclk) disable iff (!presetn)
    !pready |-> prdata == 32'h0000_0000)
    else $error("read data outside answer cycle");

  // Main scenarios
  bypass_c: cover property (@(posedge pclk) disable iff (!presetn)
    port5_ctrl[p5_sel4_bit] && port5_ctrl[p5_bypass_bit]);
  crystal_c: cover property (@(posedge pclk) disable iff (!presetn)
    port5_ctrl[p5_sel4_bit] && !port5_ctrl[p5_bypass_bit]);
  comp_sel_c: cover property (@(posedge pclk) disable iff (!presetn) |comp_onehot);
  jtag_c: cover property (@(posedge pclk) disable iff (!presetn) jtag_mode);
  bad_addr_c: cover property (@(posedge pclk) disable iff (!presetn) pslverr);
endmodule

// file: pin_partner.sv
// Model of the package pins outside the pin select block
`timescale 1ns/1ps
module pin_partner (
  input wire logic pclk,
  input wire logic [7:0] port5_out,
  input wire logic [7:0] port5_oe,
  input wire logic [7:0] port6_out,
  input wire logic [7:0] port6_oe,
  input wire logic [3:0] portj_out,
  input wire logic [3:0] portj_oe,
  input wire logic [3:0] portj_pull,
  output logic [7:0] port5_in,
  output logic [7:0] port6_in,
  output logic [3:0] portj_in
);
  // Floating pins toggle so no stale level hides a missing driver
  logic flip = 1'b0;
  // Toggle source for undriven pins
  always @(posedge pclk) begin
    flip <= ~flip;
  end
  // Pin level from driver, else pull-up, else floating pattern
  assign port5_in = (port5_out & port5_oe) | (~port5_oe & {8{flip}});
  assign port6_in = (port6_out & port6_oe) | (~port6_oe & {8{flip}});
  assign portj_in = (portj_out & portj_oe) | (~portj_oe & (portj_pull | {4{flip}}));
endmodule

// file: tb_port_pin_function_select.sv
// Self-checking bench for the port pin function select block
`timescale 1ns/1ps
module tb_port_pin_function_select;
  import pin_select_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata, rd;
  logic pready, pslverr, err;
  logic [7:0] p5_in, p5_out, p5_oe, p5_ie, p6_in, p6_out, p6_oe, p6_ie, p6_an;
  logic [3:0] pj_in, pj_out, pj_oe, pj_pull;
  logic jtag_mode = 1'b0;
  logic [3:0] jtag_out = 4'h0, jtag_oe = 4'h0;
  logic osc_en, osc_byp;
  int error_cnt = 0, checks_done = 0, cycles = 0;
  port_pin_function_select port_pin_function_select_i (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .port5_in(p5_in),
    .port5_out(p5_out), .port5_oe(p5_oe), .port5_ie(p5_ie), .port6_in(p6_in),
    .port6_out(p6_out), .port6_oe(p6_oe), .port6_ie(p6_ie), .portj_in(pj_in),
    .portj_out(pj_out), .portj_oe(pj_oe), .portj_pull(pj_pull), .jtag_mode(jtag_mode),
    .jtag_out(jtag_out), .jtag_oe(jtag_oe), .osc_enable(osc_en),
    .osc_bypass_mode(osc_byp), .port6_analog(p6_an));
  pin_partner pin_partner_i (.pclk(pclk), .port5_out(p5_out), .port5_oe(p5_oe),
    .port6_out(p6_out), .port6_oe(p6_oe), .portj_out(pj_out), .portj_oe(pj_oe),
    .portj_pull(pj_pull), .port5_in(p5_in), .port6_in(p6_in), .portj_in(pj_in));
  // 100 MHz clock
  initial begin
    forever #5 pclk = ~pclk;
  end
  // Compare one value, count and report a difference
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // One APB transfer; holds the request until pready is seen high, then releases
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Answer looked at mid-cycle, where it has settled
    do begin
      @(negedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
    repeat (2) @(posedge pclk);
  endtask
  // Verdict, reached from the main sequence or the timeout
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // Hang guard, far above the roughly 100 cycles the tests need
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 5000) begin
      error_cnt++;
      tally_and_finish();
    end
  end
  // Main sequence
  initial begin
    repeat (12) @(posedge pclk);
    chk({p5_oe, p6_oe, p5_ie, p6_ie}, 32'h0000_ffff);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b1, port5_ctrl_offset, 32'h0000_ffa5);
    chk({p5_oe, p5_out}, 32'h0000_ffa5);
    apb(1'b0, pin_status_offset, 32'h0);
    chk(rd[7:0], 32'h0000_00a5);
    apb(1'b1, port5_ctrl_offset, 32'h0001_ffa5);
    chk({osc_en, osc_byp, p5_oe}, 32'h0000_02cf);
    apb(1'b1, port5_ctrl_offset, 32'h0003_ffa5);
    chk({osc_en, osc_byp, p5_oe}, 32'h0000_03ef);
    apb(1'b0, port5_ctrl_offset, 32'h0);
    chk(rd, 32'h0003_ffa5);
    apb(1'b1, port6_ctrl_offset, 32'h0c00_ff5a);
    chk({p6_oe, p6_ie}, 32'h0000_f3f3);
    chk(p6_an, 32'h0000_000c);
    chk(p6_out, 32'h0000_005a);
    apb(1'b0, pin_effect_offset, 32'h0);
    chk(rd, 32'h00f3_00ef);
    apb(1'b1, port6_ctrl_offset, 32'h0000_ff00);
    for (int ch = 0; ch < 8; ch++) begin
      apb(1'b1, comp_ctrl_offset, 32'h0000_0010 | ch);
      chk({p6_oe, p6_ie}, {16'h0000, ~(8'h01 << ch), ~(8'h01 << ch)});
    end
    apb(1'b1, comp_ctrl_offset, 32'h0000_0000);
    chk(p6_oe, 32'h0000_00ff);
    jtag_mode <= 1'b1;
    apb(1'b1, portj_ctrl_offset, 32'h0000_0f00);
    chk(pj_pull, 32'h0000_000e);
    apb(1'b1, portj_ctrl_offset, 32'h0000_00f0);
    chk({pj_pull, pj_oe}, 32'h0000_00e0);
    jtag_oe <= 4'hf;
    jtag_out <= 4'h5;
    repeat (3) @(posedge pclk);
    chk({pj_oe, pj_out}, 32'h0000_00f5);
    jtag_mode <= 1'b0;
    jtag_oe <= 4'h0;
    repeat (3) @(posedge pclk);
    chk({pj_oe, pj_pull}, 32'h0000_00f0);
    apb(1'b0, 8'h20, 32'h0);
    chk({31'h0, err}, 32'h0000_0001);
    chk(rd, 32'h0000_0000);
    tally_and_finish();
  end
endmodule
